// ---- rtl/rtc_trim_pkg.sv ----
// constants for the periodic digital rate trim block
package rtc_trim_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h01;
    localparam logic [ADDR_W-1:0] IDX_DIGITAL_TRIM = 8'h08;
    localparam logic [ADDR_W-1:0] IDX_LOAD_CAP_TRIM = 8'h12;

    // reset values
    localparam logic [7:0] RST_DIGITAL_TRIM = 8'h00;
    localparam logic [7:0] RST_LOAD_CAP_TRIM = 8'h00;
    localparam logic RST_OSC_STOP = 1'b0;

    // digital_rate_trim fields
    localparam int MAG_LSB = 0;
    localparam int MAG_W = 5;
    localparam int SIGN_BIT = 5;
    localparam int FT_BIT = 6;
    localparam int OUT_BIT = 7;

    // load_cap_trim fields, steps of 0.25 pF
    localparam int CAP_MAG_W = 7;
    localparam int CAP_SIGN_BIT = 7;
    localparam logic [7:0] CAP_DEFAULT_Q = 8'h64;
    localparam logic [6:0] CAP_MAX_ADD_Q = 7'h27;
    localparam logic [6:0] CAP_MAX_REMOVE_Q = 7'h48;

    // control register fields
    localparam int OSC_STOP_BIT = 0;

    // status register fields
    localparam int ST_HUND_LSB = 0;
    localparam int ST_SEC_LSB = 8;
    localparam int ST_MIN_LSB = 16;
    localparam int ST_CORR_BIT = 24;

    // timing
    localparam int OSC_HZ = 32768;
    localparam int TRIM_STAGE_HZ = 512;
    localparam int PRESCALE = OSC_HZ / TRIM_STAGE_HZ;
    localparam int DIV_NORMAL = 512;
    localparam int DIV_FAST = 511;
    localparam int DIV_SLOW = 513;
    localparam int TICKS_PER_SEC = 100;
    localparam int SEC_PER_MIN = 60;
    localparam int CYCLE_MIN_POS = 8;
    localparam int CYCLE_MIN_NEG = 16;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- rtl/osc_prescaler.sv ----
// oscillator pin synchroniser and uncorrected divider down to 512 Hz
module osc_prescaler #(
    parameter int PRESCALE = 64
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic osc_in,
    input wire logic run,
    output logic tick_double,
    output logic tick_stage
);
    localparam int CW = $clog2(PRESCALE);

    logic [2:0] sync_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    wire osc_rise = sync_r[1] & ~sync_r[2];
    wire step = osc_rise & run;
    wire half_wrap = cnt_r[CW-2:0] == {(CW-1){1'b1}};
    wire full_wrap = cnt_r == {CW{1'b1}};

    assign cnt_nxt = step ? cnt_r + 1'b1 : cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_r <= 3'b000;
            cnt_r <= '0;
            tick_double <= 1'b0;
            tick_stage <= 1'b0;
        end else begin
            sync_r <= {sync_r[1:0], osc_in};
            cnt_r <= cnt_nxt;
            tick_double <= step & half_wrap;
            tick_stage <= step & full_wrap;
        end
    end
endmodule

// ---- rtl/rtc_rate_trim.sv ----
// periodic digital rate trim with axi4-lite register access
// How it works
// - all timing derives from 32768 Hz oscillator
// - normally 100 output ticks per 512 inputs
// - 100 Hz ticks count the fraction register
// - positive correction second: 100 per 511
// - negative correction second: 100 per 513
// - zero magnitude keeps normal ratio
// - first N seconds of cycle are corrected
// - cycle is 8 or 16 minutes
// - magnitude is five low bits, 0..31
// - bit 5 is sign, 1 speeds up
// - step about +4.068 or -2.034 ppm
// - trim acts at 512 Hz stage only
// - test output taken before corrected stage
// - analog trim sets load capacitance code
// - test pin toggles at 512 Hz when FT and OUT bits are both set and osc stop is clear
// - trim leaves test timing untouched
//
// Local design decision: the AXI4-Lite slave port.
module rtc_rate_trim (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic osc_in,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rtc_trim_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [rtc_trim_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [rtc_trim_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [rtc_trim_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic hundredths_tick,
    output logic mp_out,
    output logic [7:0] input_side_load_cap,
    output logic [7:0] output_side_load_cap
);
    import rtc_trim_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] idx);
        hit = addr == ADDR_W'({idx, 2'b00});
    endfunction

    // software state
    logic [7:0] digital_rate_trim_r;
    logic [7:0] load_cap_trim_r;
    logic osc_stop_r;

    // time keeping state
    logic [9:0] acc_r;
    logic [6:0] hund_r;
    logic [5:0] sec_r;
    logic [3:0] min_r;
    logic toggle_r;

    // bus state
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0] wbyte_r;
    logic wstrb0_r;

    wire tick_double;
    wire tick_stage;

    wire [MAG_W-1:0] trim_magnitude = digital_rate_trim_r[MAG_LSB +: MAG_W];
    wire trim_sign = digital_rate_trim_r[SIGN_BIT];
    wire freq_test_enable = digital_rate_trim_r[FT_BIT];
    wire out_level = digital_rate_trim_r[OUT_BIT];

    // oscillator prescaler, 32768 Hz down to 512 Hz
    osc_prescaler #(
        .PRESCALE(PRESCALE)
    ) u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_in(osc_in),
        .run(~osc_stop_r),
        .tick_double(tick_double),
        .tick_stage(tick_stage)
    );

    // cycle window: every 8th or 16th minute
    wire window_pos = min_r[2:0] == 3'(CYCLE_MIN_POS % 8);
    wire window_neg = min_r == 4'(CYCLE_MIN_NEG % 16);
    wire in_window = trim_sign ? window_pos : window_neg;
    // first N seconds of the cycle; N nonzero
    wire corr_active = (trim_magnitude != '0) & in_window &
                       (sec_r < {1'b0, trim_magnitude});
    // one step is one corrected second
    // pick the divisor for this second
    wire [9:0] div_sel = !corr_active ? 10'(DIV_NORMAL) :
                         trim_sign ? 10'(DIV_FAST) : 10'(DIV_SLOW);

    // 100 ticks per divisor inputs at the 512 Hz stage
    wire [10:0] acc_sum = {1'b0, acc_r} + 11'(TICKS_PER_SEC);
    wire emit = tick_stage & (acc_sum >= {1'b0, div_sel});
    wire [10:0] acc_less = acc_sum - {1'b0, div_sel};
    wire [9:0] acc_nxt = emit ? acc_less[9:0] :
                         tick_stage ? acc_sum[9:0] : acc_r;

    wire hund_wrap = hund_r == 7'(TICKS_PER_SEC - 1);
    wire sec_wrap = sec_r == 6'(SEC_PER_MIN - 1);
    wire [6:0] hund_nxt = !emit ? hund_r :
                          hund_wrap ? 7'h00 : hund_r + 7'h01;
    wire sec_step = emit & hund_wrap;
    wire [5:0] sec_nxt = !sec_step ? sec_r :
                         sec_wrap ? 6'h00 : sec_r + 6'h01;
    // minute rollover starts each correction cycle
    wire [3:0] min_nxt = (sec_step & sec_wrap) ? min_r + 4'h1 : min_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= 10'h000;
            hund_r <= 7'h00;
            sec_r <= 6'h00;
            min_r <= 4'h0;
            hundredths_tick <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            hund_r <= hund_nxt;
            sec_r <= sec_nxt;
            min_r <= min_nxt;
            hundredths_tick <= emit;
        end
    end

    // test pin fed from uncorrected 1024 Hz edges
    wire test_mode = freq_test_enable & out_level & ~osc_stop_r;
    wire toggle_nxt = !test_mode ? 1'b0 :
                      tick_double ? ~toggle_r : toggle_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toggle_r <= 1'b0;
            mp_out <= 1'b0;
        end else begin
            toggle_r <= toggle_nxt;
            mp_out <= test_mode ? toggle_nxt : out_level;
        end
    end

    // load capacitance per side in 0.25 pF steps
    wire [CAP_MAG_W-1:0] cap_mag = load_cap_trim_r[CAP_MAG_W-1:0];
    wire cap_remove = load_cap_trim_r[CAP_SIGN_BIT];
    wire cap_valid = cap_remove ? (cap_mag <= CAP_MAX_REMOVE_Q) :
                                  (cap_mag <= CAP_MAX_ADD_Q);
    wire [7:0] cap_q = !cap_valid ? CAP_DEFAULT_Q :
                       cap_remove ? CAP_DEFAULT_Q - {1'b0, cap_mag} :
                                    CAP_DEFAULT_Q + {1'b0, cap_mag};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_side_load_cap <= CAP_DEFAULT_Q;
            output_side_load_cap <= CAP_DEFAULT_Q;
        end else begin
            input_side_load_cap <= cap_q;
            output_side_load_cap <= cap_q;
        end
    end

    // write channel
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire aw_held_nxt = do_write ? 1'b0 : (aw_take | aw_held_r);
    wire w_held_nxt = do_write ? 1'b0 : (w_take | w_held_r);
    wire bvalid_nxt = do_write | (s_axi_bvalid & ~s_axi_bready);

    wire wr_ctrl = hit(awaddr_r, IDX_CTRL);
    wire wr_status = hit(awaddr_r, IDX_STATUS);
    wire wr_dig = hit(awaddr_r, IDX_DIGITAL_TRIM);
    wire wr_cap = hit(awaddr_r, IDX_LOAD_CAP_TRIM);
    wire wr_mapped = wr_ctrl | wr_status | wr_dig | wr_cap;
    wire wr_en = do_write & wstrb0_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wbyte_r <= 8'h00;
            wstrb0_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                wbyte_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            s_axi_awready <= ~aw_held_nxt;
            s_axi_wready <= ~w_held_nxt;
            s_axi_bvalid <= bvalid_nxt;
            if (do_write) begin
                s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // trim registers take effect at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            digital_rate_trim_r <= RST_DIGITAL_TRIM;
            load_cap_trim_r <= RST_LOAD_CAP_TRIM;
            osc_stop_r <= RST_OSC_STOP;
        end else begin
            if (wr_en & wr_dig) begin
                digital_rate_trim_r <= wbyte_r;
            end
            if (wr_en & wr_cap) begin
                load_cap_trim_r <= wbyte_r;
            end
            if (wr_en & wr_ctrl) begin
                osc_stop_r <= wbyte_r[OSC_STOP_BIT];
            end
        end
    end

    // read channel
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rvalid_nxt = ar_take | (s_axi_rvalid & ~s_axi_rready);

    wire rd_ctrl = hit(s_axi_araddr, IDX_CTRL);
    wire rd_status = hit(s_axi_araddr, IDX_STATUS);
    wire rd_dig = hit(s_axi_araddr, IDX_DIGITAL_TRIM);
    wire rd_cap = hit(s_axi_araddr, IDX_LOAD_CAP_TRIM);
    wire rd_mapped = rd_ctrl | rd_status | rd_dig | rd_cap;

    wire [DATA_W-1:0] status_word =
        (DATA_W'(corr_active) << ST_CORR_BIT) |
        (DATA_W'(min_r) << ST_MIN_LSB) |
        (DATA_W'(sec_r) << ST_SEC_LSB) |
        (DATA_W'(hund_r) << ST_HUND_LSB);
    wire [DATA_W-1:0] rd_word =
        rd_ctrl ? (DATA_W'(osc_stop_r) << OSC_STOP_BIT) :
        rd_status ? status_word :
        rd_dig ? DATA_W'(digital_rate_trim_r) :
        rd_cap ? DATA_W'(load_cap_trim_r) : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_nxt;
            s_axi_rvalid <= rvalid_nxt;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end
endmodule

// ---- verif/rtc_trim_properties.sv ----
// port assertions for the rate trim block
module rtc_trim_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [rtc_trim_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic hundredths_tick,
    input wire logic [7:0] input_side_load_cap,
    input wire logic [7:0] output_side_load_cap
);
    import rtc_trim_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    aw_busy_a:
    assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address taken twice");
    r_lat_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    b_lat_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    tick_gap_a:
    assert property (hundredths_tick |=> !hundredths_tick [*8])
        else $error("hundredths ticks too close");
    cap_match_a:
    assert property (input_side_load_cap == output_side_load_cap)
        else $error("load cap sides differ");
    cap_range_a:
    assert property (input_side_load_cap >= 8'h1C &&
        input_side_load_cap <= 8'h8B)
        else $error("load cap out of range");
endmodule
bind rtc_rate_trim rtc_trim_checker u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .hundredths_tick(hundredths_tick),
    .input_side_load_cap(input_side_load_cap),
    .output_side_load_cap(output_side_load_cap)
);

// ---- verif/tb_top.sv ----
// register and rate tests for the rate trim block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_trim_pkg::*;
    logic aclk, aresetn, osc_in, osc_run, hundredths_tick, mp_out;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [7:0] input_side_load_cap, output_side_load_cap;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int fail_count, n_tests, h_cnt, p_cnt;
    logic mp_q;
    logic [7:0] cw [4] = '{8'h0C, 8'hC8, 8'h27, 8'h28};
    logic [7:0] ce [4] = '{8'h70, 8'h1C, 8'h8B, 8'h64};
    logic [7:0] tw [4] = '{8'h21, 8'h20, 8'h03, 8'h80};
    logic te [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic tm [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

    rtc_rate_trim u_dut (
        .aclk(aclk),
        .aresetn(aresetn),
        .osc_in(osc_in),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(s_axi_awprot),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .hundredths_tick(hundredths_tick),
        .mp_out(mp_out),
        .input_side_load_cap(input_side_load_cap),
        .output_side_load_cap(output_side_load_cap)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        mp_q <= mp_out;
        if (osc_run) osc_in <= ~osc_in;
        if (osc_run && hundredths_tick === 1'b1) h_cnt <= h_cnt + 1;
        if (osc_run && mp_out === 1'b1 && mp_q === 1'b0) begin
            p_cnt <= p_cnt + 1;
        end
    end

    task automatic do_reset();
        aresetn <= 1'b0;
        osc_in <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        h_cnt = 0;
        p_cnt = 0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic tick(ref int i);
        @(posedge aclk);
        i++;
        if (i > 50) begin
            check("handshake", 1, 0);
            conclude();
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        int i;
        i = 0;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        do begin
            tick(i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
    endtask

    task automatic rd_reg(logic [7:0] a);
        int i;
        i = 0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin
            tick(i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    initial begin
        {aresetn, osc_in, osc_run, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        {h_cnt, p_cnt, fail_count, n_tests} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_reg(8'h20);
        check("trim reset", 32'h0, rd);
        rd_reg(8'h48);
        check("cap reg reset", 32'h0, rd);
        check("cap reset", 32'h64, input_side_load_cap);
        rd_reg(8'h08);
        check("unmapped resp", 32'h2, rsp);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h48, cw[k]);
            rd_reg(8'h48);
            check("cap reg", cw[k], rd);
            check("cap in side", ce[k], input_side_load_cap);
            check("cap out side", ce[k], output_side_load_cap);
        end
        $display("test load cap done");
        wr(8'h20, 32'hFFFF_FF21);
        rd_reg(8'h20);
        check("trim fields", 32'h21, rd);
        for (int k = 0; k < 4; k++) begin
            wr(8'h20, tw[k]);
            rd_reg(8'h04);
            check("corr second", te[k], rd[24]);
            check("out level", tm[k], mp_out);
        end
        $display("test trim fields done");
        wr(8'h20, 32'hE1);
        osc_run <= 1'b1;
        repeat (511 * 128 + 64) @(posedge aclk);
        osc_run <= 1'b0;
        repeat (8) @(posedge aclk);
        check("fast ticks", 100, h_cnt);
        check("test pin rises", 511, p_cnt);
        rd_reg(8'h04);
        check("status after", 32'h100, rd);
        $display("test ratio done");
        do_reset();
        rd_reg(8'h20);
        check("trim after reset", 32'h0, rd);
        wr(8'h20, 32'hC3);
        osc_run <= 1'b1;
        repeat (128 * 128 + 64) @(posedge aclk);
        osc_run <= 1'b0;
        repeat (8) @(posedge aclk);
        check("slow ticks", 24, h_cnt);
        check("test pin steady", 128, p_cnt);
        rd_reg(8'h04);
        check("status slow", 32'h0100_0018, rd);
        $display("test slow ratio done");
        wr(8'h00, 32'h1);
        rd_reg(8'h00);
        check("osc stop", 32'h1, rd);
        check("stopped pin", 1, mp_out);
        osc_run <= 1'b1;
        repeat (600) @(posedge aclk);
        osc_run <= 1'b0;
        repeat (8) @(posedge aclk);
        check("stopped ticks", 24, h_cnt);
        check("stopped pin rises", 128, p_cnt);
        rd_reg(8'h04);
        check("status stopped", 32'h0100_0018, rd);
        $display("test osc stop done");
        conclude();
    end
endmodule
